// [verilog/hub_string_charge_boost_cfg.sv]
`timescale 1ns/1ps
`include "hub_cfg_map.svh"
module hub_string_charge_boost_cfg
   import hub_cfg_pkg::*;
#(
   parameter int CHARS = `MAX_CHARS
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // configuration writer byte port
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [7:0]  cfg_wdata,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   output logic      [7:0]  cfg_rdata,
   output logic             cfg_rvalid,
   // descriptor character fetch
   input  wire logic        char_req,
   input  wire logic        char_sel,
   input  wire logic [4:0]  char_idx,
   output logic      [15:0] char_data,
   output logic             char_present,
   output logic             char_valid,
   // static controls
   output logic      [3:0]  charge_port_enable,
   output logic      [1:0]  upstream_drive_level
);
   localparam int DEPTH = 2 * CHARS;

   if (DEPTH != int'(`PROD_LAST) - int'(`PROD_BASE) + 1 ||
       DEPTH != int'(`SER_LAST) - int'(`SER_BASE) + 1)
   begin : size_check
      $error("CHARS does not fit the text address ranges");
   end

   cfg_state_type s_q;
   cfg_state_type s_d;
   text_bus_if    tb ();

   text_store #(.DEPTH(DEPTH)) store_u (
      .clk (clk),
      .bus (tb)
   );

   logic       in_prod;
   logic       in_ser;
   logic [7:0] off;
   logic [5:0] cfg_idx;
   logic       issue;
   logic [7:0] eff_len;

   always_comb
   begin
      s_d     = s_q;
      in_prod = (cfg_addr >= `PROD_BASE) && (cfg_addr <= `PROD_LAST);
      in_ser  = (cfg_addr >= `SER_BASE) && (cfg_addr <= `SER_LAST);
      off     = in_ser ? cfg_addr - `SER_BASE : cfg_addr - `PROD_BASE;
      // serial characters sit after the product ones in the shared store
      cfg_idx = in_ser ? 6'(CHARS) + off[6:1] : off[6:1];
      issue   = char_req && !cfg_rd && (s_q.st == st_idle);
      eff_len = char_sel ? s_q.ser_len : s_q.prod_len;

      // byte writes: even offset is the low byte, odd the high byte
      tb.wr_en   = cfg_wr && (in_prod || in_ser);
      tb.wr_be   = off[0] ? 2'b10 : 2'b01;
      tb.wr_idx  = cfg_idx;
      tb.wr_data = {cfg_wdata, cfg_wdata};
      // configuration reads win the single read port
      tb.rd_en   = (cfg_rd && (in_prod || in_ser)) || issue;
      tb.rd_idx  = cfg_rd ? cfg_idx : (char_sel ? 6'(CHARS) + {1'b0, char_idx}
                                                : {1'b0, char_idx});

      if (cfg_wr)
      begin
         case (cfg_addr)
            `CHARGE_ADDR:   s_d.charge = cfg_wdata[`CHARGE_MSB:`CHARGE_LSB];
            `BOOST_ADDR:    s_d.boost  = cfg_wdata[`BOOST_MSB:`BOOST_LSB];
            `PROD_LEN_ADDR: s_d.prod_len = cfg_wdata;
            `SER_LEN_ADDR:  s_d.ser_len  = cfg_wdata;
            default:        s_d.charge = s_q.charge;
         endcase
      end

      // read pipeline stage one: pick source, reserved bits read zero
      s_d.rd_pend = cfg_rd;
      s_d.rd_mem  = in_prod || in_ser;
      s_d.rd_hi   = off[0];
      case (cfg_addr)
         `CHARGE_ADDR:   s_d.rd_reg = {3'h0, s_q.charge, 1'b0};
         `BOOST_ADDR:    s_d.rd_reg = {6'h00, s_q.boost};
         `PROD_LEN_ADDR: s_d.rd_reg = s_q.prod_len;
         `SER_LEN_ADDR:  s_d.rd_reg = s_q.ser_len;
         default:        s_d.rd_reg = 8'h00;
      endcase
      // stage two
      s_d.rvalid = s_q.rd_pend;
      if (s_q.rd_pend)
         s_d.rdata = !s_q.rd_mem ? s_q.rd_reg
                   : (s_q.rd_hi ? tb.rd_data[15:8] : tb.rd_data[7:0]);

      s_d.ch_valid = 1'b0;
      case (s_q.st)
         st_idle:
         begin
            if (issue)
            begin
               s_d.st = st_fetch;
               // lengths above the table size are capped at the table size
               s_d.ch_present = (8'(char_idx) < eff_len) &&
                                (32'(char_idx) < CHARS);
            end
         end
         st_fetch:
         begin
            s_d.st       = st_hold;
            s_d.ch_valid = 1'b1;
            s_d.ch_data  = s_q.ch_present ? tb.rd_data : 16'h0000;
         end
         st_hold:  s_d.st = st_idle;
         default:  s_d.st = st_idle;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q          <= '0;
         s_q.charge   <= `CHARGE_RST;
         s_q.boost    <= `BOOST_RST;
         s_q.prod_len <= `LEN_RST;
         s_q.ser_len  <= `LEN_RST;
         s_q.st       <= st_idle;
      end
      else
         s_q <= s_d;
   end

   assign cfg_rdata            = s_q.rdata;
   assign cfg_rvalid           = s_q.rvalid;
   assign char_data            = s_q.ch_data;
   assign char_present         = s_q.ch_present;
   assign char_valid           = s_q.ch_valid;
   assign charge_port_enable   = s_q.charge;
   assign upstream_drive_level = s_q.boost;

   // helpers for checks
   logic [7:0] len_seen;
   logic [4:0] idx_seen;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         len_seen <= 8'h00;
         idx_seen <= 5'h00;
      end
      else if (issue)
      begin
         len_seen <= eff_len;
         idx_seen <= char_idx;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // byte placement in the shared store
   prod_write_a: assert property (
      cfg_wr && cfg_addr == 8'h55 |-> tb.wr_en && tb.wr_idx == 6'd0 && tb.wr_be == 2'b10)
      else $error("product byte misplaced");
   ser_write_a: assert property (
      cfg_wr && cfg_addr == 8'h94 |-> tb.wr_en && tb.wr_idx == 6'(CHARS + 1) && tb.wr_be == 2'b01)
      else $error("serial byte misplaced");
   ser_last_a: assert property (
      cfg_wr && cfg_addr == `SER_LAST |-> tb.wr_idx == 6'(DEPTH - 1) && tb.wr_be == 2'b10)
      else $error("last serial byte misplaced");
   table_end_a: assert property (
      cfg_wr && (cfg_addr == 8'h53 || cfg_addr == 8'hd0) |-> !tb.wr_en)
      else $error("write outside text tables");
   low_first_a: assert property (
      cfg_wr && (in_prod || in_ser) && !off[0] |-> tb.wr_be == 2'b01)
      else $error("low byte not at even address");
   high_next_a: assert property (
      cfg_wr && (in_prod || in_ser) && off[0]
         |-> tb.wr_be == 2'b10 && tb.wr_data[15:8] == cfg_wdata)
      else $error("high byte not at odd address");

   charge_follow_a: assert property (
      cfg_wr && cfg_addr == `CHARGE_ADDR |=> charge_port_enable == $past(cfg_wdata[4:1]))
      else $error("charge enable not updated");
   charge_steady_a: assert property (
      !(cfg_wr && cfg_addr == `CHARGE_ADDR) |=> $stable(charge_port_enable))
      else $error("charge enable changed without write");
   charge_rsvd_a: assert property (
      cfg_rd && cfg_addr == `CHARGE_ADDR
         |-> ##2 cfg_rvalid && cfg_rdata[7:5] == 3'h0 && !cfg_rdata[0])
      else $error("reserved charge bits not zero");
   boost_follow_a: assert property (
      cfg_wr && cfg_addr == `BOOST_ADDR |=> upstream_drive_level == $past(cfg_wdata[1:0]))
      else $error("boost not updated");
   boost_rsvd_a: assert property (
      cfg_rd && cfg_addr == `BOOST_ADDR |-> ##2 cfg_rvalid && cfg_rdata[7:2] == 6'h00)
      else $error("reserved boost bits not zero");
   boost_steady_a: assert property (
      !(cfg_wr && cfg_addr == `BOOST_ADDR) |=> $stable(upstream_drive_level))
      else $error("boost changed without write");

   length_gate_a: assert property (
      char_valid |-> char_present == (8'(idx_seen) < len_seen && idx_seen != 5'd31))
      else $error("character reported against length");
   absent_zero_a: assert property (
      char_valid && !char_present |-> char_data == 16'h0000)
      else $error("absent character not zero");
   fetch_time_a: assert property (
      issue |-> ##2 char_valid ##1 !char_valid)
      else $error("character answer late");

   string_read_c: cover property (cfg_rd && in_ser ##2 cfg_rvalid);
   char_shown_c: cover property (char_valid && char_present);
   char_absent_c: cover property (char_valid && !char_present);
   boost_high_c: cover property (upstream_drive_level == 2'b11);
   charge_write_c: cover property (cfg_wr && cfg_addr == `CHARGE_ADDR);
endmodule

// [verilog/hub_cfg_map.svh]
`ifndef HUB_CFG_MAP_SVH
`define HUB_CFG_MAP_SVH
// Contract
// - product text occupies byte addresses 54h to 91h, two bytes per UTF-16LE character.
// - serial text occupies byte addresses 92h to cfh, two bytes per UTF-16LE character.
// - each text table holds at most 31 characters in 62 bytes, never more.
// - a character keeps its low byte at the lower address and its high byte at the next.
// - a downstream port has charging support enabled exactly when its enable bit is 1.
// - charge enable bits 4 to 1 serve ports 4 to 1; bits 7 to 5 and bit 0 are reserved.
// - upstream drive bits 1:0 pick no, low, medium or high boost; bits 7:2 are reserved.
// - separate product and serial length registers decide how many characters are reported.

// byte addresses
`define PROD_BASE      8'h54
`define PROD_LAST      8'h91
`define SER_BASE       8'h92
`define SER_LAST       8'hcf
`define CHARGE_ADDR    8'hd0
`define BOOST_ADDR     8'hf6
`define PROD_LEN_ADDR  8'h14
`define SER_LEN_ADDR   8'h15

// sizes and fields
`define MAX_CHARS      31
`define CHARGE_LSB     1
`define CHARGE_MSB     4
`define BOOST_LSB      0
`define BOOST_MSB      1

// reset values
`define CHARGE_RST     4'h0
`define BOOST_RST      2'h0
`define LEN_RST        8'h00

// cycles from request to answer
`define READ_LAT       2
`endif

// [verilog/hub_cfg_pkg.sv]
package hub_cfg_pkg;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_fetch = 2'b01,
      st_hold  = 2'b10
   } fetch_state_type;

   typedef struct packed {
      logic [3:0]      charge;
      logic [1:0]      boost;
      logic [7:0]      prod_len;
      logic [7:0]      ser_len;
      logic            rd_pend;
      logic            rd_mem;
      logic            rd_hi;
      logic [7:0]      rd_reg;
      logic [7:0]      rdata;
      logic            rvalid;
      fetch_state_type st;
      logic            ch_present;
      logic [15:0]     ch_data;
      logic            ch_valid;
   } cfg_state_type;

endpackage

// [verilog/text_bus_if.sv]
`timescale 1ns/1ps
interface text_bus_if;
   logic        wr_en;
   logic [1:0]  wr_be;
   logic [5:0]  wr_idx;
   logic [15:0] wr_data;
   logic        rd_en;
   logic [5:0]  rd_idx;
   logic [15:0] rd_data;

   modport store (input wr_en, wr_be, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
   modport user  (output wr_en, wr_be, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
endinterface

// [verilog/text_store.sv]
`timescale 1ns/1ps
module text_store #(
   parameter int DEPTH = 62
) (
   // clock
   input  wire logic clk,
   // character port
   text_bus_if.store bus
);
   // the character index is six bits wide
   if (DEPTH < 1 || DEPTH > 64)
   begin : depth_check
      $error("DEPTH does not fit the character index");
   end

   // one memory per byte lane so low and high halves fill independently
   // and no two processes share a variable
   for (genvar g = 0; g < 2; g++)
   begin : lane
      logic [7:0] mem [DEPTH];
      logic [7:0] rd_q;

      always_ff @(posedge clk)
      begin
         if (bus.wr_en && bus.wr_be[g])
            mem[bus.wr_idx] <= bus.wr_data[8*g +: 8];
         if (bus.rd_en)
            rd_q <= mem[bus.rd_idx];
      end

      assign bus.rd_data[8*g +: 8] = rd_q;
   end
endmodule

// [verification/test_hub_string_charge_boost_cfg.sv]
`timescale 1ns/1ps
module test_hub_string_charge_boost_cfg;
   logic        clk;
   logic        rstn;
   logic [7:0]  cfg_addr;
   logic [7:0]  cfg_wdata;
   logic        cfg_wr;
   logic        cfg_rd;
   logic [7:0]  cfg_rdata;
   logic        cfg_rvalid;
   logic        char_req;
   logic        char_sel;
   logic [4:0]  char_idx;
   logic [15:0] char_data;
   logic        char_present;
   logic        char_valid;
   logic [3:0]  charge_port_enable;
   logic [1:0]  upstream_drive_level;
   int          mismatches;
   int          checks;

   hub_string_charge_boost_cfg DUT (
      .clk                  (clk),
      .rstn                 (rstn),
      .cfg_addr             (cfg_addr),
      .cfg_wdata            (cfg_wdata),
      .cfg_wr               (cfg_wr),
      .cfg_rd               (cfg_rd),
      .cfg_rdata            (cfg_rdata),
      .cfg_rvalid           (cfg_rvalid),
      .char_req             (char_req),
      .char_sel             (char_sel),
      .char_idx             (char_idx),
      .char_data            (char_data),
      .char_present         (char_present),
      .char_valid           (char_valid),
      .charge_port_enable   (charge_port_enable),
      .upstream_drive_level (upstream_drive_level)
   );

   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      char_req = 1'b0;
      char_sel = 1'b0;
      char_idx = 5'h00;
      mismatches = 0;
      checks = 0;
   end

   always #2.5 clk = ~clk;

   task automatic report_and_stop();
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_addr  <= a;
      cfg_wdata <= d;
      cfg_wr    <= 1'b1;
      @(posedge clk);
      cfg_wr    <= 1'b0;
   endtask

   // bounded wait: a lost answer must not hang the run
   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      @(posedge clk);
      cfg_addr <= a;
      cfg_rd   <= 1'b1;
      @(posedge clk);
      cfg_rd   <= 1'b0;
      while (cfg_rvalid !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         n++;
      end
      cmp({what, " answered"}, 16'h0001, {15'h0000, cfg_rvalid});
      cmp({what, " wait"}, 16'h0002, 16'(n));
      cmp(what, {8'h00, exp}, {8'h00, cfg_rdata});
   endtask

   task automatic fetch(input logic s, input logic [4:0] i, input logic p, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      char_req <= 1'b1;
      char_sel <= s;
      char_idx <= i;
      while (char_valid !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         n++;
      end
      char_req <= 1'b0;
      cmp("char_valid", 16'h0001, {15'h0000, char_valid});
      cmp("char_wait", 16'h0003, 16'(n));
      cmp("char_present", {15'h0000, p}, {15'h0000, char_present});
      cmp("char_data", d, char_data);
      // keep the minimum spacing between fetches
      repeat (4) @(posedge clk);
   endtask

   task automatic t_reset();
      rd("prod_len", 8'h14, 8'h00);
      rd("ser_len", 8'h15, 8'h00);
      rd("charge", 8'hd0, 8'h00);
      rd("boost", 8'hf6, 8'h00);
      cmp("charge_out", 16'h0000, {12'h000, charge_port_enable});
      cmp("boost_out", 16'h0000, {14'h0000, upstream_drive_level});
      cmp("char_data", 16'h0000, char_data);
   endtask

   task automatic t_charge();
      wr(8'hd0, 8'hff);
      rd("charge", 8'hd0, 8'h1e);
      cmp("charge_out", 16'h000f, {12'h000, charge_port_enable});
      wr(8'hd0, 8'he5);
      rd("charge", 8'hd0, 8'h04);
      cmp("charge_out", 16'h0002, {12'h000, charge_port_enable});
   endtask

   task automatic t_boost();
      for (int c = 0; c < 4; c++)
      begin
         wr(8'hf6, {6'h3f, 2'(c)});
         rd("boost", 8'hf6, {6'h00, 2'(c)});
         wr(8'hd0, 8'h00);
         cmp("boost_out", 16'(c), {14'h0000, upstream_drive_level});
      end
   endtask

   task automatic t_tables();
      wr(8'h54, 8'h34);
      wr(8'h55, 8'h12);
      wr(8'h90, 8'h78);
      wr(8'h91, 8'h56);
      wr(8'h92, 8'hbc);
      wr(8'h93, 8'h9a);
      wr(8'hce, 8'hf0);
      wr(8'hcf, 8'hde);
      rd("prod_first", 8'h54, 8'h34);
      rd("prod_last", 8'h91, 8'h56);
      rd("ser_first", 8'h92, 8'hbc);
      rd("ser_last", 8'hcf, 8'hde);
   endtask

   task automatic t_fetch();
      wr(8'h14, 8'h1f);
      wr(8'h15, 8'h01);
      rd("ser_len", 8'h15, 8'h01);
      fetch(1'b0, 5'd0, 1'b1, 16'h1234);
      fetch(1'b0, 5'd30, 1'b1, 16'h5678);
      fetch(1'b1, 5'd0, 1'b1, 16'h9abc);
      fetch(1'b1, 5'd1, 1'b0, 16'h0000);
      wr(8'h15, 8'h1f);
      fetch(1'b1, 5'd30, 1'b1, 16'hdef0);
      wr(8'h14, 8'h00);
      fetch(1'b0, 5'd0, 1'b0, 16'h0000);
      // a length beyond the table still stops at 31 characters
      wr(8'h14, 8'hff);
      fetch(1'b0, 5'd30, 1'b1, 16'h5678);
      fetch(1'b0, 5'd31, 1'b0, 16'h0000);
   endtask

   task automatic t_unmapped();
      rd("unmapped", 8'h00, 8'h00);
      wr(8'hf7, 8'h01);
      rd("boost_kept", 8'hf6, 8'h03);
      wr(8'hf6, 8'h00);
      rd("boost_idle", 8'hf6, 8'h00);
      cmp("boost_out", 16'h0000, {14'h0000, upstream_drive_level});
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_charge();
      t_boost();
      t_tables();
      t_fetch();
      t_unmapped();
      report_and_stop();
   end

   // whole run is well under two thousand cycles
   initial
   begin
      #25000;
      mismatches++;
      report_and_stop();
   end
endmodule
